// *** slr_defs.vh ***
`ifndef SLR_DEFS_VH
`define SLR_DEFS_VH
// register byte offsets
`define SLR_PMC_OFS 8'h00
`define SLR_HWC_OFS 8'h04
`define SLR_RST_OFS 8'h08
`define SLR_ISTS_OFS 8'h0C
`define SLR_IEN_OFS 8'h10
`define SLR_STRAP_OFS 8'h14
// power management control fields
`define SLR_PMC_READY 0
`define SLR_PMC_MODE_LO 12
`define SLR_PMC_MODE_HI 13
// hardware config fields
`define SLR_HWC_READY 27
// reset control fields
`define SLR_RST_CORE 6
// interrupt status fields
`define SLR_IRQ_READY 30
// power state encodings
`define SLR_PM_FULL 2'h0
// timing in ns and derived cycle counts at 4 ns
`define SLR_CLK_NS 4
`define SLR_PLL_NS 100000
`define SLR_PLL_CYC ((`SLR_PLL_NS + `SLR_CLK_NS - 1) / `SLR_CLK_NS)
// strap latch settle time after reset release
`define SLR_SETTLE_CYC 4
`endif

// *** slr_strap_latch_and_ready.v ***
// Behaviour
// - one ready bit, readable in power control and hardware config registers.
// - after any reset, ready rises only once eeprom load completes.
// - core reset via reset control forces eeprom reload; ready low meanwhile.
// - any power state other than full power drives ready low.
// - on wake, ready rises after full power and pll settle time.
// - straps are captured only on power-on, core or pin reset.
// - latched straps act as direct settings or register defaults.
// - eeprom size strap low selects small range, high selects large range.
// - topology strap selects two port, downstream or upstream port arrangement.
// - link polarity strap sets active level of external link input.
// - transmit shift strap selects 0, 10, 20 or 30 ns shift.
// - per-phy fibre strap puts that phy in fibre mode.
// - per-phy loss strap puts that phy in loss-of-signal detect mode.
// - rising edge of ready sets the ready interrupt status flag.
`timescale 1ns/100ps
`include "slr_defs.vh"
module slr_strap_latch_and_ready #(
   parameter PLL_CYC = `SLR_PLL_CYC
) (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // strap pins (asynchronous)
   input wire eepromSizeStrap,
   input wire [1:0] topologyStrap,
   input wire linkPolStrap,
   input wire [1:0] txShiftStrap,
   input wire phyAFiberStrap,
   input wire phyBFiberStrap,
   input wire phyASignalLossStrap,
   input wire phyBSignalLossStrap,
   // external link indicator pin
   input wire extLinkPin,
   // eeprom loader handshake
   output wire eepromLoadStart,
   input wire eepromLoadDone,
   // power management
   input wire pllLocked,
   // configuration outputs
   output reg eepromLargeRange,
   output reg [1:0] portMode,
   output reg extPortEnable,
   output reg extPortIsPort0,
   output reg [1:0] txShiftSel,
   output reg [5:0] txShiftNs,
   output reg phyAFiberSelect,
   output reg phyBFiberSelect,
   output reg phyASignalLossSelect,
   output reg phyBSignalLossSelect,
   output reg extLinkUp,
   output wire coreReset,
   output reg [1:0] powerState,
   output wire deviceReady,
   output wire irq,
   // axi4-lite slave
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   // sequencer states
   localparam ST_LATCH = 3'h0;
   localparam ST_LOAD = 3'h1;
   localparam ST_WAIT = 3'h2;
   localparam ST_READY = 3'h3;
   localparam ST_SLEEP = 3'h4;
   localparam ST_PLL = 3'h5;
   // straps, link pin, loader done and pll lock all cross into this clock
   localparam SYNC_W = 13;

   // synchronised pin levels
   wire [SYNC_W-1:0] pinRaw;
   wire [SYNC_W-1:0] pinSync;
   wire [9:0] strapSync;
   wire linkSync;
   wire doneSync;
   wire pllSync;
   genvar gi;

   // sequencer state and dwell counter
   reg [2:0] state;
   reg [2:0] next_state;
   reg [31:0] cnt;
   reg doneDropped;
   reg linkPolLatched;

   // ready bit, interrupt flag and reload request
   reg readyBit;
   reg readyPrev;
   reg coreRstReq;
   reg readyStatus;
   reg readyEnable;
   wire readyRise;

   // bus capture registers and decoded write strobes
   reg awTaken;
   reg wTaken;
   reg [7:0] awAddr;
   reg [31:0] wData;
   reg [3:0] wStrb;
   wire writeFire;
   wire coreRstWrite;
   wire [1:0] pmWrite;
   wire pmWriteEn;
   wire ienWriteEn;
   wire istsClear;

   // two-flop synchroniser per pin; only the second flop is read, so a
   // metastable first flop has a full cycle to settle
   assign pinRaw = {eepromSizeStrap, topologyStrap, linkPolStrap, txShiftStrap,
                    phyAFiberStrap, phyBFiberStrap, phyASignalLossStrap,
                    phyBSignalLossStrap, extLinkPin, eepromLoadDone, pllLocked};
   generate
      for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
         reg meta;
         reg sync;
         always @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
               meta <= 1'b0;
               sync <= 1'b0;
            end else begin
               meta <= pinRaw[gi];
               sync <= meta;
            end
         end
         assign pinSync[gi] = sync;
      end
   endgenerate

   // unpack the synchronised vector
   assign strapSync = pinSync[12:3];
   assign linkSync = pinSync[2];
   assign doneSync = pinSync[1];
   assign pllSync = pinSync[0];

   // sequencer: latch straps, load eeprom, ready, sleep, pll settle
   always @* begin
      next_state = state;
      case (state)
         ST_LATCH: if (cnt >= `SLR_SETTLE_CYC) next_state = ST_LOAD;
         ST_LOAD: next_state = ST_WAIT;
         ST_WAIT: begin
            // a done level left from the previous load must not end this one
            if (doneSync && doneDropped) begin
               if (powerState == `SLR_PM_FULL) next_state = ST_READY;
               else next_state = ST_SLEEP;
            end
         end
         ST_READY: begin
            if (coreRstReq) next_state = ST_LATCH;
            else if (powerState != `SLR_PM_FULL) next_state = ST_SLEEP;
         end
         ST_SLEEP: if (powerState == `SLR_PM_FULL) next_state = ST_PLL;
         ST_PLL: begin
            if (powerState != `SLR_PM_FULL) next_state = ST_SLEEP;
            else if (pllSync && cnt >= PLL_CYC) next_state = ST_READY;
         end
         default: next_state = ST_LATCH;
      endcase
   end

   // state register; the dwell counter restarts on every state change
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_LATCH;
         cnt <= 32'h0000_0000;
      end else begin
         state <= next_state;
         if (next_state != state || (state == ST_PLL && !pllSync)) cnt <= 32'h0000_0000;
         else cnt <= cnt + 32'h0000_0001;
      end
   end

   // the loader must drop done after the start pulse before done may end a load
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         doneDropped <= 1'b0;
      end else if (state == ST_LOAD) begin
         doneDropped <= 1'b0;
      end else if (state == ST_WAIT && !doneSync) begin
         doneDropped <= 1'b1;
      end
   end

   // loader start pulse, and core held in reset while straps latch and load
   assign eepromLoadStart = (state == ST_LOAD);
   assign coreReset = (state == ST_LATCH) || (state == ST_LOAD) || (state == ST_WAIT);

   // strap capture only at the end of a reset or core reload settle window
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         eepromLargeRange <= 1'b0;
         portMode <= 2'h0;
         txShiftSel <= 2'h0;
         linkPolLatched <= 1'b0;
         phyAFiberSelect <= 1'b0;
         phyBFiberSelect <= 1'b0;
         phyASignalLossSelect <= 1'b0;
         phyBSignalLossSelect <= 1'b0;
      end else if (state == ST_LATCH && next_state == ST_LOAD) begin
         eepromLargeRange <= strapSync[9];
         portMode <= strapSync[8:7];
         linkPolLatched <= strapSync[6];
         txShiftSel <= strapSync[5:4];
         phyAFiberSelect <= strapSync[3];
         phyBFiberSelect <= strapSync[2];
         phyASignalLossSelect <= strapSync[1];
         phyBSignalLossSelect <= strapSync[0];
      end
   end

   // direct settings decoded from latched straps
   // they follow the latched straps one cycle later
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         extPortEnable <= 1'b0;
         extPortIsPort0 <= 1'b0;
         txShiftNs <= 6'h00;
         extLinkUp <= 1'b0;
      end else begin
         extPortEnable <= portMode[1];
         extPortIsPort0 <= (portMode == 2'h3);
         txShiftNs <= {1'b0, txShiftSel, 3'h0} + {3'h0, txShiftSel, 1'b0}; // 8x plus 2x
         extLinkUp <= ~(linkSync ^ linkPolLatched);
      end
   end

   // ready bit and its interrupt
   // ready follows next_state, so it drops in the cycle the sequencer leaves ready
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         readyBit <= 1'b0;
         readyPrev <= 1'b0;
         readyStatus <= 1'b0;
      end else begin
         readyBit <= (next_state == ST_READY);
         readyPrev <= readyBit;
         if (readyRise) readyStatus <= 1'b1; // set wins
         else if (istsClear) readyStatus <= 1'b0;
      end
   end
   assign deviceReady = readyBit;
   assign irq = readyStatus && readyEnable;
   assign readyRise = readyBit && !readyPrev;

   // axi4-lite write path
   // a new address or data beat waits until the previous response is taken
   assign s_axi_awready = !awTaken && !s_axi_bvalid;
   assign s_axi_wready = !wTaken && !s_axi_bvalid;
   assign writeFire = awTaken && wTaken && !s_axi_bvalid;
   assign pmWriteEn = writeFire && awAddr == `SLR_PMC_OFS && wStrb[1];
   assign pmWrite = wData[`SLR_PMC_MODE_HI:`SLR_PMC_MODE_LO];
   assign coreRstWrite = writeFire && awAddr == `SLR_RST_OFS && wStrb[0]
                         && wData[`SLR_RST_CORE];
   assign ienWriteEn = writeFire && awAddr == `SLR_IEN_OFS && wStrb[3];
   assign istsClear = writeFire && awAddr == `SLR_ISTS_OFS && wStrb[3]
                      && wData[`SLR_IRQ_READY];

   // address and data are taken in either order; the response follows both
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         awTaken <= 1'b0;
         wTaken <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0000_0000;
         wStrb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awTaken <= 1'b1;
            awAddr <= {s_axi_awaddr[7:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wTaken <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (writeFire) begin
            awTaken <= 1'b0;
            wTaken <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (awAddr <= `SLR_STRAP_OFS) ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // software writable fields; a reload request written while asleep waits for ready
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         powerState <= `SLR_PM_FULL;
         readyEnable <= 1'b0;
         coreRstReq <= 1'b0;
      end else begin
         if (pmWriteEn) powerState <= pmWrite;
         if (ienWriteEn) readyEnable <= wData[`SLR_IRQ_READY];
         if (coreRstWrite) coreRstReq <= 1'b1;
         else if (state == ST_LATCH) coreRstReq <= 1'b0;
      end
   end

   // axi4-lite read path
   // arready drops while an answer waits to be taken
   assign s_axi_arready = !s_axi_rvalid;
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h0000_0000;
         // one word per register; unmapped offsets answer with a slave error
         case ({s_axi_araddr[7:2], 2'h0})
            `SLR_PMC_OFS: s_axi_rdata <= ({30'h0, powerState} << `SLR_PMC_MODE_LO)
                                         | {31'h0, readyBit};
            `SLR_HWC_OFS: s_axi_rdata <= {4'h0, readyBit, 27'h0};
            `SLR_RST_OFS: s_axi_rdata <= {25'h0, coreRstReq, 6'h00};
            `SLR_ISTS_OFS: s_axi_rdata <= {1'b0, readyStatus, 30'h0};
            `SLR_IEN_OFS: s_axi_rdata <= {1'b0, readyEnable, 30'h0};
            `SLR_STRAP_OFS: s_axi_rdata <= {22'h0, eepromLargeRange, portMode,
                                           linkPolLatched, txShiftSel, phyAFiberSelect,
                                           phyBFiberSelect, phyASignalLossSelect,
                                           phyBSignalLossSelect};
            default: s_axi_rresp <= 2'h2;
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // slr_strap_latch_and_ready

// *** slr_eeprom_model.sv ***
`timescale 1ns/100ps
// loader stand-in: a start pulse drops done, which returns after lat plus four cycles
module slr_eeprom_model (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // loader handshake
   input wire eepromLoadStart,
   input wire [3:0] lat,
   output reg eepromLoadDone
);
   reg [4:0] cnt;
   // done stays low long enough for the two-flop sync to see the drop
   always @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         eepromLoadDone <= 1'b0;
         cnt <= 5'h00;
      end else if (eepromLoadStart) begin
         eepromLoadDone <= 1'b0;
         cnt <= {1'b0, lat} + 5'h04;
      end else if (cnt != 5'h00) begin
         cnt <= cnt - 5'h01;
         eepromLoadDone <= (cnt == 5'h01);
      end
   end
endmodule // slr_eeprom_model

// *** slr_monitor.sv ***
`timescale 1ns/100ps
`include "slr_defs.vh"
module slr_monitor (
   // clock and reset
   input wire ref_clk,
   input wire sys_rst,
   // configuration and ready
   input wire eepromLoadDone,
   input wire eepromLargeRange,
   input wire [1:0] portMode,
   input wire extPortEnable,
   input wire extPortIsPort0,
   input wire [1:0] txShiftSel,
   input wire [5:0] txShiftNs,
   input wire coreReset,
   input wire [1:0] powerState,
   input wire deviceReady,
   input wire irq,
   // bus answers
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // ready, configuration and bus answer relations
   property p_pm_low; (powerState != `SLR_PM_FULL) [*3] |-> !deviceReady; endproperty
   a_pm_low: assert property (p_pm_low) else $error("ready high in power save");
   property p_wake; $rose(deviceReady) |-> powerState == `SLR_PM_FULL; endproperty
   a_wake: assert property (p_wake) else $error("ready rose outside full power");
   property p_core; coreReset [*4] |-> !deviceReady; endproperty
   a_core: assert property (p_core) else $error("ready high during reload");
   property p_load; $rose(deviceReady) |-> $past(eepromLoadDone, 3); endproperty
   a_load: assert property (p_load) else $error("ready rose before load done");
   property p_hold; !coreReset && !$past(coreReset) && !$past(coreReset, 2)
      |-> $stable({eepromLargeRange, portMode, txShiftSel}); endproperty
   a_hold: assert property (p_hold) else $error("latched straps moved");
   property p_port;
      {extPortEnable, extPortIsPort0} == {$past(portMode[1]), $past(portMode) == 2'h3};
   endproperty
   a_port: assert property (p_port) else $error("port arrangement wrong");
   property p_shift; txShiftNs == $past(txShiftSel) * 6'h0A; endproperty
   a_shift: assert property (p_shift) else $error("shift ns wrong");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   // main scenarios
   c_reload: cover property ($rose(coreReset));
   c_sleep: cover property ($fell(powerState == `SLR_PM_FULL));
   c_irq: cover property ($rose(irq));
endmodule // slr_monitor
bind slr_strap_latch_and_ready slr_monitor mon_u (.*);

// *** slr_strap_latch_and_ready_tb.sv ***
`timescale 1ns/100ps
`include "slr_defs.vh"
module slr_strap_latch_and_ready_tb;
   reg ref_clk = 1'b0;
   reg sys_rst = 1'b1;
   reg [9:0] s = 10'h000;
   reg [9:0] o;
   reg extLinkPin = 1'b0;
   reg pllLocked = 1'b1;
   reg [3:0] lat = 4'h3;
   reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h0, rd, r;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   reg [1:0] rr;
   integer seed = 32'hf1a09824, n_errors = 0, n_checks = 0, i;
   wire eepromLoadStart, eepromLoadDone, eepromLargeRange, extPortEnable, extPortIsPort0;
   wire phyAFiberSelect, phyBFiberSelect, phyASignalLossSelect, phyBSignalLossSelect;
   wire extLinkUp, coreReset, deviceReady, irq, s_axi_awready, s_axi_wready;
   wire s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] portMode, txShiftSel, powerState, s_axi_bresp, s_axi_rresp;
   wire [5:0] txShiftNs;
   wire [31:0] s_axi_rdata;
   // strap pins follow the strap vector
   wire eepromSizeStrap = s[9], linkPolStrap = s[6];
   wire [1:0] topologyStrap = s[8:7], txShiftStrap = s[5:4];
   wire phyAFiberStrap = s[3], phyBFiberStrap = s[2];
   wire phyASignalLossStrap = s[1], phyBSignalLossStrap = s[0];
   slr_strap_latch_and_ready #(.PLL_CYC(8)) dut_u (.*);
   slr_eeprom_model em_u (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .eepromLoadStart(eepromLoadStart), .lat(lat), .eepromLoadDone(eepromLoadDone));
   // 250 MHz clock
   initial forever #2 ref_clk = ~ref_clk;
   task close_out;
      begin
         $display("checks %0d errors %0d", n_checks, n_errors);
         if (n_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
         else $display("CHECKS NOT OK");
         $finish;
      end
   endtask
   task chk(input string nm, input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("Error %s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   task hang;
      begin
         n_errors = n_errors + 1;
         $display("Error wait expected done seen timeout");
         close_out;
      end
   endtask
   // one write: address and data offered together, each dropped when taken
   task axw(input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge ref_clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         for (n = 0; n < 100; n = n + 1) begin
            @(posedge ref_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
         end
         s_axi_bready <= 1'b0;
         if (n == 100) hang;
      end
   endtask
   task axr(input [7:0] a);
      integer n;
      begin
         @(posedge ref_clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         for (n = 0; n < 100; n = n + 1) begin
            @(posedge ref_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
         end
         rd = s_axi_rdata;
         rr = s_axi_rresp;
         s_axi_rready <= 1'b0;
         if (n == 100) hang;
      end
   endtask
   task waitr(input v);
      integer n;
      begin
         for (n = 0; n < 2000; n = n + 1) begin
            @(posedge ref_clk);
            if (deviceReady === v) break;
         end
         if (n == 2000) hang;
      end
   endtask
   function [5:0] ns(input [1:0] c);
      ns = c * 6'h0A;
   endfunction
   task cfg(input [9:0] v);
      begin
         chk("straps", {eepromLargeRange, portMode, txShiftSel, phyAFiberSelect, phyBFiberSelect,
            phyASignalLossSelect, phyBSignalLossSelect}, {v[9:7], v[5:0]});
         chk("port", {extPortEnable, extPortIsPort0}, {v[8], v[8:7] == 2'h3});
         chk("shiftns", txShiftNs, ns(v[5:4]));
         axr(`SLR_STRAP_OFS);
         chk("readback", rd, {22'h0, v});
      end
   endtask
   task lnk(input [9:0] v);
      begin
         extLinkPin <= v[6];
         repeat (5) @(posedge ref_clk);
         chk("linkup", extLinkUp, 1);
         extLinkPin <= ~v[6];
         repeat (5) @(posedge ref_clk);
         chk("linkdown", extLinkUp, 0);
      end
   endtask
   // reset, first load, then sleep, wake and core reload passes
   initial begin
      s = $random(seed);
      repeat (8) @(posedge ref_clk);
      sys_rst <= 1'b0;
      waitr(1);
      cfg(s);
      lnk(s);
      axr(`SLR_PMC_OFS);
      chk("pmready", rd[`SLR_PMC_READY], 1);
      axr(`SLR_HWC_OFS);
      chk("hwready", rd[`SLR_HWC_READY], 1);
      axr(`SLR_ISTS_OFS);
      chk("readyflag", rd[`SLR_IRQ_READY], 1);
      chk("irqmasked", irq, 0);
      axw(`SLR_IEN_OFS, 32'h40000000);
      chk("irqon", irq, 1);
      axw(`SLR_ISTS_OFS, 32'h40000000);
      @(posedge ref_clk);
      chk("irqclr", irq, 0);
      axr(8'h18);
      chk("slverr", rr, 2'h2);
      $display("test basic done");
      for (i = 0; i < 4; i = i + 1) begin
         o = s;
         r = $random(seed);
         s <= {r[9], i[1:0], r[6], i[1:0], r[3:0]};
         lat <= r[13:10];
         axw(`SLR_PMC_OFS, 32'h00001000);
         pllLocked <= 1'b0;
         repeat (6) @(posedge ref_clk);
         chk("sleep", deviceReady, 0);
         cfg(o);
         axw(`SLR_PMC_OFS, 32'h0);
         repeat (20) @(posedge ref_clk);
         chk("nopll", deviceReady, 0);
         pllLocked <= 1'b1;
         waitr(1);
         axr(`SLR_ISTS_OFS);
         chk("wakeflag", rd[`SLR_IRQ_READY], 1);
         axw(`SLR_ISTS_OFS, 32'h40000000);
         axw(`SLR_RST_OFS, 32'h00000040);
         waitr(0);
         repeat (8) @(posedge ref_clk);
         chk("reloading", deviceReady, 0);
         waitr(1);
         cfg(s);
         lnk(s);
         axr(`SLR_ISTS_OFS);
         chk("reloadflag", rd[`SLR_IRQ_READY], 1);
         axw(`SLR_ISTS_OFS, 32'h40000000);
         $display("test pass %0d done", i);
      end
      close_out;
   end
endmodule // slr_strap_latch_and_ready_tb
